// [ppc_regs.vh]
// Register offsets, field positions and reset values for the phase power configuration block
`ifndef PPC_REGS_VH
`define PPC_REGS_VH
`define PPC_OFS_CFG_ONE      8'h02
`define PPC_OFS_CFG_TWO      8'h03
`define PPC_OFS_FLAG_LO      8'h04
`define PPC_OFS_FLAG_HI      8'h05
`define PPC_CFG_ONE_MASK     8'h03
`define PPC_CFG_TWO_MASK     8'h0f
`define PPC_FLAG_MASK        16'hdf07
`define PPC_CFG_RST          8'h00
`define PPC_FLAG_RST         16'h0000
`define PPC_FML_LSB          0
`define PPC_FML_MSB          1
`define PPC_APP_BIT          0
`define PPC_WIR_LSB          1
`define PPC_WIR_MSB          2
`define PPC_OFM_BIT          3
`define PPC_FML_OWN          2'h0
`define PPC_FML_NEGC         2'h1
`define PPC_FML_NEGAC        2'h2
`define PPC_FML_AMC          2'h3
`define PPC_WIR_FOUR         2'h0
`define PPC_WIR_THREE        2'h1
`define PPC_WIR_THREEVI      2'h2
`define PPC_FLG_OVERRUN      15
`define PPC_FLG_DONE         14
`define PPC_FLG_DIR          12
`define PPC_FLG_MISSING_ZERO_CROSS_FLAG         11
`define PPC_FLG_LOWV         10
`define PPC_FLG_HIGHV        9
`define PPC_FLG_HIGHI        8
`define PPC_FLG_ACCOVF       2
`define PPC_FLG_CSUM         1
`define PPC_FLG_SUPPLY       0
`endif

// [ppc_mult.v]
// Registered signed multiplier used once per phase
module ppc_mult #(
  parameter W = 16
) (
  input  wire                   i_core_clk, // Core clock
  input  wire                   i_rst,      // Async reset, high
  input  wire                   i_en,       // Load strobe
  input  wire signed [W-1:0]    i_a,        // Current operand
  input  wire signed [W+1:0]    i_b,        // Voltage operand, two guard bits
  output reg  signed [2*W:0]    o_p         // Product
);
  // Full product; its top bit only repeats the sign for legal operands
  wire signed [2*W+1:0] prod = i_a * i_b;
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      o_p <= {(2*W+1){1'b0}};
    else if (i_en)
      o_p <= prod[2*W:0];
  end
endmodule

// [ppc_top.v]
// Phase power formula, offset method, wiring coefficient and event flags
//
// Summary of operation
// - Formula code 00 makes each phase power its own current times its own voltage.
// - Formula code 01 makes phase B power its current times the negated phase C voltage.
// - Formula code 10 makes phase B power its current times minus the sum of phase A and C voltages.
// - Formula code 11 makes phase B power its current times phase A voltage minus phase C voltage.
// - Offset method bit 0 gives root of squared RMS current plus offset, bit 1 gives RMS plus offset.
// - The wiring field picks coefficient one for 00, three wire for 01, three voltages and currents for 10.
// - Overrun is flagged when a cycle starts before the last finished, done when a cycle completes.
`include "ppc_regs.vh"
module ppc_top #(
  parameter W = 16
) (
  input  wire                 i_core_clk,   // Core clock
  input  wire                 i_rst,        // Async reset, high
  input  wire                 i_wr,         // Register write strobe
  input  wire [7:0]           i_addr,       // Register offset
  input  wire [7:0]           i_wdata,      // Write data
  output reg  [7:0]           o_rdata,      // Read data
  input  wire                 i_start,      // Processing cycle start pulse
  input  wire signed [W-1:0]  i_ia,         // Phase A current
  input  wire signed [W-1:0]  i_ib,         // Phase B current
  input  wire signed [W-1:0]  i_ic,         // Phase C current
  input  wire signed [W-1:0]  i_va,         // Phase A voltage
  input  wire signed [W-1:0]  i_vb,         // Phase B voltage
  input  wire signed [W-1:0]  i_vc,         // Phase C voltage
  input  wire [W-1:0]         i_rms_current,// RMS current
  input  wire [W-1:0]         i_offset_term,// Offset term
  input  wire [7:0]           i_event_set,  // Set pulses for flags 12:8
  input  wire [2:0]           i_event_low,  // Set pulses for flags 2:0
  output reg  signed [2*W:0]  o_pa,         // Phase A power
  output reg  signed [2*W:0]  o_pb,         // Phase B power
  output reg  signed [2*W:0]  o_pc,         // Phase C power
  output reg  [2*W:0]         o_rms_current_adj,   // Offset corrected current
  output reg  [1:0]           o_wiring,     // Wiring coefficient select
  output reg                  o_app_sel,    // Application select
  output reg                  o_done,       // Results valid pulse
  output wire                 o_flag_active // Any flag set
);
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [7:0]  operating_config_one;
  reg [7:0]  operating_config_two;
  reg [15:0] event_flag_register;
  reg        busy;
  wire [1:0] power_formula_select = operating_config_one[`PPC_FML_MSB:`PPC_FML_LSB];
  wire       offset_method_select = operating_config_two[`PPC_OFM_BIT];
  wire [1:0] wiring_coefficient_select = operating_config_two[`PPC_WIR_MSB:`PPC_WIR_LSB];

  // Write strobe aimed at one register offset
  function ppc_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      ppc_hit = wr && (addr == ofs);
    end
  endfunction

  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      operating_config_one <= `PPC_CFG_RST;
      operating_config_two <= `PPC_CFG_RST;
    end
    else if (ppc_hit(i_wr, i_addr, `PPC_OFS_CFG_ONE))
      operating_config_one <= i_wdata & `PPC_CFG_ONE_MASK;
    else if (ppc_hit(i_wr, i_addr, `PPC_OFS_CFG_TWO))
      operating_config_two <= i_wdata & `PPC_CFG_TWO_MASK;
  end

  // ----------------------------------------------------------------
  // Phase B voltage operand per formula
  // ----------------------------------------------------------------
  // Two guard bits: minus A minus C reaches plus two full scales
  wire signed [W+1:0] va_x = {{2{i_va[W-1]}}, i_va};
  wire signed [W+1:0] vb_x = {{2{i_vb[W-1]}}, i_vb};
  wire signed [W+1:0] vc_x = {{2{i_vc[W-1]}}, i_vc};
  reg  signed [W+1:0] vb_sel;
  always @*
  begin
    case (power_formula_select)
      `PPC_FML_OWN:   vb_sel = vb_x;
      `PPC_FML_NEGC:  vb_sel = -vc_x;
      `PPC_FML_NEGAC: vb_sel = -va_x - vc_x;
      `PPC_FML_AMC:   vb_sel = va_x - vc_x;
      default:        vb_sel = vb_x;
    endcase
  end

  wire signed [2*W:0] pa_w;
  wire signed [2*W:0] pb_w;
  wire signed [2*W:0] pc_w;
  wire load = i_start && !busy;
  ppc_mult #(.W(W)) u_ma (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_en(load), .i_a(i_ia), .i_b(va_x), .o_p(pa_w));
  ppc_mult #(.W(W)) u_mb (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_en(load), .i_a(i_ib), .i_b(vb_sel), .o_p(pb_w));
  ppc_mult #(.W(W)) u_mc (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_en(load), .i_a(i_ic), .i_b(vc_x), .o_p(pc_w));

  // ----------------------------------------------------------------
  // Offset method: bitwise integer square root of rms^2 + offset
  // ----------------------------------------------------------------
  function [W:0] ppc_isqrt;
    input [2*W+1:0] x;
    reg   [2*W+1:0] rem;
    reg   [2*W+1:0] bitv;
    reg   [2*W+1:0] res;
    integer k;
    begin
      rem  = x;
      res  = {(2*W+2){1'b0}};
      bitv = {2'b01, {(2*W){1'b0}}};
      for (k = 0; k <= W; k = k + 1)
      begin
        if (rem >= res + bitv)
        begin
          rem = rem - (res + bitv);
          res = (res >> 1) + bitv;
        end
        else
          res = res >> 1;
        bitv = bitv >> 2;
      end
      ppc_isqrt = res[W:0];
    end
  endfunction

  // Square kept at full width before it meets the offset
  wire [2*W-1:0] rms_sq = i_rms_current * i_rms_current;
  reg [2*W+1:0] sq_sum;
  reg [W:0]     root;
  always @*
  begin
    sq_sum = {2'b00, rms_sq} + {{(W+2){1'b0}}, i_offset_term};
    root   = ppc_isqrt(sq_sum);
  end

  // ----------------------------------------------------------------
  // Processing sequence and outputs
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy       <= 1'b0;
      o_pa       <= {(2*W+1){1'b0}};
      o_pb       <= {(2*W+1){1'b0}};
      o_pc       <= {(2*W+1){1'b0}};
      o_rms_current_adj <= {(2*W+1){1'b0}};
      o_wiring   <= `PPC_WIR_FOUR;
      o_app_sel  <= 1'b0;
      o_done     <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (load)
      begin
        busy  <= 1'b1;
        if (offset_method_select)
          o_rms_current_adj <= {{(W){1'b0}}, i_rms_current} + {{(W+1){1'b0}}, i_offset_term};
        else
          o_rms_current_adj <= {{(W){1'b0}}, root};
        o_wiring  <= wiring_coefficient_select;
        o_app_sel <= operating_config_two[`PPC_APP_BIT];
      end
      else if (busy)
      begin
        busy   <= 1'b0;
        o_pa   <= pa_w;
        o_pb   <= pb_w;
        o_pc   <= pc_w;
        o_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags: set wins over host clear
  // ----------------------------------------------------------------
  reg [15:0] set_vec;
  reg [15:0] clr_vec;
  always @*
  begin
    set_vec = 16'h0000;
    set_vec[`PPC_FLG_OVERRUN] = i_start && busy;
    set_vec[`PPC_FLG_DONE]    = o_done;
    set_vec[`PPC_FLG_DIR:`PPC_FLG_HIGHI]    = i_event_set[4:0];
    set_vec[`PPC_FLG_ACCOVF:`PPC_FLG_SUPPLY] = i_event_low;
    clr_vec = 16'h0000;
    if (ppc_hit(i_wr, i_addr, `PPC_OFS_FLAG_LO))
      clr_vec[7:0] = i_wdata;
    if (ppc_hit(i_wr, i_addr, `PPC_OFS_FLAG_HI))
      clr_vec[15:8] = i_wdata;
  end

  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      event_flag_register <= `PPC_FLAG_RST;
    else
      event_flag_register <= ((event_flag_register & ~clr_vec) | set_vec) & `PPC_FLAG_MASK;
  end

  assign o_flag_active = |event_flag_register;

  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= 8'h00;
    else
    begin
      case (i_addr)
        `PPC_OFS_CFG_ONE: o_rdata <= operating_config_one;
        `PPC_OFS_CFG_TWO: o_rdata <= operating_config_two;
        `PPC_OFS_FLAG_LO: o_rdata <= event_flag_register[7:0];
        `PPC_OFS_FLAG_HI: o_rdata <= event_flag_register[15:8];
        default:          o_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// [ppc_host.sv]
// Host model that reaches the configuration and flag registers
module ppc_host (
  input  wire logic       i_core_clk, // Clock
  input  wire logic [7:0] i_rdata,    // Read data
  output logic            o_wr,       // Write strobe
  output logic      [7:0] o_addr,     // Offset
  output logic      [7:0] o_wdata     // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    @(posedge i_core_clk);
    #1 d = i_rdata;
  endtask
  // Serviced flags cleared by writing ones
  task automatic clr();
    wr(8'h04, 8'hff);
    wr(8'h05, 8'hff);
  endtask
endmodule

// [ppc_props.sv]
// Checker on the phase power block ports
module ppc_chk #(
  parameter W = 16
) (
  input wire logic                  i_core_clk,   // Clock
  input wire logic                  i_rst,        // Reset
  input wire logic        [7:0]     i_addr,       // Offset
  input wire logic        [7:0]     o_rdata,      // Read data
  input wire logic                  i_start,      // Start
  input wire logic signed [W-1:0]   i_ia,         // Current A
  input wire logic signed [W-1:0]   i_va,         // Voltage A
  input wire logic        [7:0]     i_event_set,  // Events high
  input wire logic        [2:0]     i_event_low,  // Events low
  input wire logic signed [2*W:0]   o_pa,         // Power A
  input wire logic                  o_done,       // Done
  input wire logic                  o_flag_active // Any flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_done_after_start: assert property (i_start && !$past(i_start) && !$past(i_start, 2) |-> ##2 o_done)
    else $error("no done after start");
  a_done_pulse_once: assert property (o_done |=> !o_done)
    else $error("done wider than a cycle");
  a_pa_own_product: assert property (o_done |-> o_pa == $past(i_ia, 2) * $past(i_va, 2))
    else $error("phase A power wrong");
  a_done_sets_flag: assert property (o_done |-> ##[1:2] o_flag_active)
    else $error("done flag not set");
  a_event_sets_flag: assert property ((|i_event_set[4:0]) || (|i_event_low) |=> o_flag_active)
    else $error("event flag not set");
  a_overrun_flag_set: assert property (i_start && $past(i_start) |=> o_flag_active)
    else $error("overrun flag not set");
  a_unmapped_reads_zero: assert property ($past(i_addr) < 8'h02 || $past(i_addr) > 8'h05 |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_flag_reserved_zero: assert property ($past(i_addr) == 8'h04 |-> o_rdata[7:3] == 5'h00)
    else $error("reserved flag bits set");
  c_done: cover property (o_done);
  c_overrun: cover property (i_start && $past(i_start));
  c_cleared: cover property (o_flag_active ##1 !o_flag_active);
endmodule
bind ppc_top ppc_chk #(.W(W)) chk (.i_core_clk, .i_rst, .i_addr, .o_rdata, .i_start, .i_ia, .i_va, .i_event_set,
  .i_event_low, .o_pa, .o_done, .o_flag_active);

// [testbench.sv]
// Self-checking bench for the phase power block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 16;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic signed [W-1:0] i_ia = '0, i_ib = '0, i_ic = '0, i_va = '0, i_vb = '0, i_vc = '0;
  logic [W-1:0] i_rms_current = '0, i_offset_term = '0;
  logic [7:0] i_event_set = '0, i_addr, i_wdata, o_rdata, d;
  logic [2:0] i_event_low = '0;
  logic signed [2*W:0] o_pa, o_pb, o_pc;
  logic [2*W:0] o_rms_current_adj;
  logic [1:0] o_wiring;
  logic i_wr, o_app_sel, o_done, o_flag_active;
  logic [31:0] seed = 32'h0000005c;
  int err_total = 0;
  int compares = 0;
  longint pb;
  always #2.5 i_core_clk = ~i_core_clk;
  ppc_top #(.W(W)) dut (.i_core_clk, .i_rst, .i_wr, .i_addr, .i_wdata, .o_rdata, .i_start, .i_ia, .i_ib, .i_ic,
    .i_va, .i_vb, .i_vc, .i_rms_current, .i_offset_term, .i_event_set, .i_event_low, .o_pa, .o_pb, .o_pc,
    .o_rms_current_adj, .o_wiring, .o_app_sel, .o_done, .o_flag_active);
  ppc_host host (.i_core_clk, .i_rdata(o_rdata), .o_wr(i_wr), .o_addr(i_addr), .o_wdata(i_wdata));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Floor integer square root
  function automatic longint isq(longint x);
    longint r = 0;
    longint t;
    for (int b = 16; b >= 0; b--)
    begin
      t = r | (longint'(1) << b);
      if (t * t <= x)
        r = t;
    end
    return r;
  endfunction
  task automatic chk(input logic [2*W:0] seen, input logic [2*W:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(33'(d), 33'(e));
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_done();
    for (int n = 0; n < 20; n++)
    begin
      @(posedge i_core_clk);
      #1;
      if (o_done === 1'b1)
        return;
    end
    err_total++;
    tally_and_finish();
  endtask
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    for (int a = 1; a < 8; a++)
      rdc(8'(a), 8'h00);
    host.wr(8'h02, 8'hff);
    rdc(8'h02, 8'h03);
    host.wr(8'h03, 8'hff);
    rdc(8'h03, 8'h0f);
    for (int k = 0; k < 4; k++)
    begin
      host.wr(8'h02, 8'(k));
      host.wr(8'h03, {4'h0, k[0], 2'(k % 3), k[1]});
      @(posedge i_core_clk);
      {i_ia, i_ib, i_ic, i_va, i_vb, i_vc, i_rms_current, i_offset_term} <= {xs(), k == 2 ?
        {xs() & 32'hffff0000 | 32'h00008000, xs() & 32'hffff0000 | 32'h00008000} : {xs(), xs()}, k == 3 ? '1 : xs()};
      i_start <= 1'b1;
      @(posedge i_core_clk);
      i_start <= 1'b0;
      wait_done();
      case (k)
        0: pb = i_ib * i_vb;
        1: pb = i_ib * -i_vc;
        2: pb = i_ib * (-i_va - i_vc);
        default: pb = i_ib * (i_va - i_vc);
      endcase
      chk(o_pa, i_ia * i_va);
      chk(o_pb, 33'(pb));
      chk(o_pc, i_ic * i_vc);
      chk(o_rms_current_adj, k[0] ? i_rms_current + i_offset_term : 33'(isq(longint'(i_rms_current) ** 2 + i_offset_term)));
      chk(33'(o_wiring), 33'(k % 3));
      chk(33'(o_app_sel), 33'(k[1]));
    end
    rdc(8'h05, 8'h40);
    host.clr();
    rdc(8'h05, 8'h00);
    @(posedge i_core_clk);
    i_start <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_start <= 1'b0;
    #1;
    chk(33'(o_done), 33'h1);
    rdc(8'h05, 8'hc0);
    host.clr();
    @(posedge i_core_clk);
    i_event_set <= 8'(xs()) | 8'h1f;
    i_event_low <= 3'h7;
    @(posedge i_core_clk);
    i_event_set <= 8'h00;
    i_event_low <= 3'h0;
    rdc(8'h04, 8'h07);
    rdc(8'h05, 8'h1f);
    host.clr();
    @(posedge i_core_clk);
    #1;
    chk(33'(o_flag_active), 33'h0);
    tally_and_finish();
  end
endmodule
